// ---- logic/lss_led_strap.sv ----
// LED drivers, strap capture and serial EEPROM pin control for a five-port switch.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Link LED high when port has no link
// - Link LED steady low on idle link
// - Link LED blinks during traffic
// - All port LEDs are active low
// - Duplex LED high half duplex, blinks collisions
// - Duplex LED steady low at full duplex
// - Capture back pressure strap, default enabled
// - Capture autonegotiation strap, default enabled
// - Latch both address straps into chip address
// - Capture crossover strap, default disabled
// - Capture colour strap, low means single colour
// - Select active high, released during reset
// - Drive serial clock, released during reset
// - Drive serial data, released during reset
// - Address zero makes device read EEPROM
module lss_led_strap
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic [4:0]  port_link_i,
    input  wire logic [4:0]  port_activity_i,
    input  wire logic [4:0]  port_full_duplex_i,
    input  wire logic [4:0]  port_collision_i,
    input  wire logic [4:0]  port_speed100_i,
    input  wire logic        backpressure_strap_i,
    input  wire logic        autoneg_strap_i,
    input  wire logic        chip_addr_strap_hi_i,
    input  wire logic        chip_addr_strap_lo_i,
    input  wire logic        crossover_strap_i,
    input  wire logic        led_color_strap_i,
    input  wire logic        eeprom_serial_in_i,
    input  wire logic        eeprom_start_i,
    output logic [4:0]       link_activity_led_o,
    output logic [4:0]       duplex_collision_led_o,
    output logic [4:0]       port_speed_led_o,
    output logic             backpressure_en_o,
    output logic             autoneg_en_o,
    output logic [1:0]       chip_addr_o,
    output logic             crossover_en_o,
    output logic             dual_color_o,
    output logic             eeprom_master_o,
    output logic             eeprom_select_o,
    output logic             eeprom_select_oe_n_o,
    output logic             eeprom_serial_clock_o,
    output logic             eeprom_serial_clock_oe_n_o,
    output logic             eeprom_serial_out_o,
    output logic             eeprom_serial_out_oe_n_o,
    output logic             eeprom_bit_valid_o,
    output logic             eeprom_bit_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------

    // Straps come from pins, so each passes three flops; a level counts once
    // the second and third stages agree.
    logic [2:0] sync_bp;
    logic [2:0] sync_an;
    logic [2:0] sync_hi;
    logic [2:0] sync_lo;
    logic [2:0] sync_xo;
    logic [2:0] sync_col;
    logic [2:0] sync_ein;

    // One process carries all pin synchronisers; reset does not clear them so
    // that the straps are already settled while reset is held.
    always_ff @(posedge core_clk_i)
    begin
        sync_bp  <= {sync_bp[1:0],  backpressure_strap_i};
        sync_an  <= {sync_an[1:0],  autoneg_strap_i};
        sync_hi  <= {sync_hi[1:0],  chip_addr_strap_hi_i};
        sync_lo  <= {sync_lo[1:0],  chip_addr_strap_lo_i};
        sync_xo  <= {sync_xo[1:0],  crossover_strap_i};
        sync_col <= {sync_col[1:0], led_color_strap_i};
        sync_ein <= {sync_ein[1:0], eeprom_serial_in_i};
    end

    // Returns the agreed level, or the previous value while stages differ.
    function automatic logic settled(input logic [2:0] s, input logic prev);
        settled = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------

    // Straps track the pins throughout reset and freeze at its release, which
    // is before any shared pin starts driving.
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            backpressure_en_o <= settled(sync_bp, backpressure_en_o);
            autoneg_en_o      <= settled(sync_an, autoneg_en_o);
            chip_addr_o       <= {settled(sync_hi, chip_addr_o[1]),
                                  settled(sync_lo, chip_addr_o[0])};
            crossover_en_o    <= settled(sync_xo, crossover_en_o);
            dual_color_o      <= settled(sync_col, dual_color_o);
        end
    end

    // Master mode when both address straps were low.
    always_ff @(posedge core_clk_i)
    begin
        eeprom_master_o <= (chip_addr_o == lss_pkg::ADDR_RESET);
    end

    // ------------------------------------------------------------
    // Blink timing
    // ------------------------------------------------------------

    // One shared half-period tick makes every blinking LED toggle on the same cycle.
    logic [19:0] blink_cnt;
    logic        blink_tick;

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            blink_cnt  <= lss_pkg::BLINK_RESET;
            blink_tick <= 1'b0;
        end
        else if (blink_cnt == 20'(lss_pkg::BLINK_CYCLES - 1))
        begin
            blink_cnt  <= lss_pkg::BLINK_RESET;
            blink_tick <= 1'b1;
        end
        else
        begin
            blink_cnt  <= blink_cnt + 20'h00001;
            blink_tick <= 1'b0;
        end
    end

    // Each event reloads a short hold so brief frames still show a visible
    // blink; a limitation is that traffic shorter than one tick may blink once.
    logic [1:0] act_hold [lss_pkg::NUM_PORTS];
    logic [1:0] col_hold [lss_pkg::NUM_PORTS];
    logic [4:0] act_phase;
    logic [4:0] col_phase;

    always_ff @(posedge core_clk_i)
    begin
        for (int p = 0; p < lss_pkg::NUM_PORTS; p++)
        begin
            if (!nrst_i)
            begin
                act_hold[p]  <= lss_pkg::HOLD_RESET;
                col_hold[p]  <= lss_pkg::HOLD_RESET;
                act_phase[p] <= 1'b0;
                col_phase[p] <= 1'b0;
            end
            else
            begin
                if (port_activity_i[p] && port_link_i[p])
                    act_hold[p] <= lss_pkg::HOLD_HALVES;
                else if (blink_tick && act_hold[p] != lss_pkg::HOLD_RESET)
                    act_hold[p] <= act_hold[p] - 2'h1;
                if (port_collision_i[p])
                    col_hold[p] <= lss_pkg::HOLD_HALVES;
                else if (blink_tick && col_hold[p] != lss_pkg::HOLD_RESET)
                    col_hold[p] <= col_hold[p] - 2'h1;
                if (act_hold[p] == lss_pkg::HOLD_RESET)
                    act_phase[p] <= 1'b0;
                else if (blink_tick)
                    act_phase[p] <= ~act_phase[p];
                if (col_hold[p] == lss_pkg::HOLD_RESET)
                    col_phase[p] <= 1'b0;
                else if (blink_tick)
                    col_phase[p] <= ~col_phase[p];
            end
        end
    end

    // ------------------------------------------------------------
    // LED outputs
    // ------------------------------------------------------------

    // All LEDs are active low and stay dark (high) while reset is held.
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            link_activity_led_o    <= lss_pkg::LED_DARK;
            duplex_collision_led_o <= lss_pkg::LED_DARK;
            port_speed_led_o       <= lss_pkg::LED_DARK;
        end
        else
        begin
            for (int p = 0; p < lss_pkg::NUM_PORTS; p++)
            begin
                if (!port_link_i[p])
                    link_activity_led_o[p] <= 1'b1;
                else if (act_hold[p] != lss_pkg::HOLD_RESET)
                    link_activity_led_o[p] <= act_phase[p];
                else
                    link_activity_led_o[p] <= 1'b0;
                if (col_hold[p] != lss_pkg::HOLD_RESET)
                    duplex_collision_led_o[p] <= col_phase[p];
                else
                    duplex_collision_led_o[p] <= ~port_full_duplex_i[p];
                port_speed_led_o[p] <= ~port_speed100_i[p];
            end
        end
    end

    // ------------------------------------------------------------
    // EEPROM pins
    // ------------------------------------------------------------

    // A minimal bit reader: it toggles the serial clock and samples the data
    // input; the command protocol lives elsewhere and drives eeprom_start_i.
    lss_pkg::lss_ee_state_t ee_state;
    logic [3:0]             ee_div;

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            ee_state                   <= lss_pkg::LSS_IDLE;
            ee_div                     <= 4'h0;
            eeprom_select_o            <= 1'b0;
            eeprom_select_oe_n_o       <= 1'b1;
            eeprom_serial_clock_o      <= 1'b0;
            eeprom_serial_clock_oe_n_o <= 1'b1;
            eeprom_serial_out_o        <= 1'b0;
            eeprom_serial_out_oe_n_o   <= 1'b1;
            eeprom_bit_valid_o         <= 1'b0;
            eeprom_bit_o               <= 1'b1;
        end
        else
        begin
            eeprom_select_oe_n_o       <= 1'b0;
            eeprom_serial_clock_oe_n_o <= 1'b0;
            eeprom_serial_out_oe_n_o   <= 1'b0;
            eeprom_bit_valid_o         <= 1'b0;
            case (ee_state)
                lss_pkg::LSS_IDLE:
                begin
                    eeprom_select_o       <= 1'b0;
                    eeprom_serial_clock_o <= 1'b0;
                    ee_div                <= 4'h0;
                    if (eeprom_master_o && eeprom_start_i)
                        ee_state <= lss_pkg::LSS_READ;
                end
                lss_pkg::LSS_READ:
                begin
                    eeprom_select_o <= 1'b1;
                    if (ee_div == lss_pkg::EE_DIV_HALF)
                    begin
                        ee_div                <= 4'h0;
                        eeprom_serial_clock_o <= ~eeprom_serial_clock_o;
                        if (eeprom_serial_clock_o)
                        begin
                            eeprom_bit_o       <= settled(sync_ein, eeprom_bit_o);
                            eeprom_bit_valid_o <= 1'b1;
                            ee_state           <= lss_pkg::LSS_DONE;
                        end
                    end
                    else
                        ee_div <= ee_div + 4'h1;
                end
                lss_pkg::LSS_DONE:
                begin
                    eeprom_serial_clock_o <= 1'b0;
                    if (!eeprom_start_i)
                        ee_state <= lss_pkg::LSS_IDLE;
                end
                default:
                    ee_state <= lss_pkg::LSS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    AST_NO_LINK_DARK: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !port_link_i[0] |=> link_activity_led_o[0])
        else $error("link LED lit without link");
    AST_IDLE_LIT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        port_link_i[0] && act_hold[0] == 2'h0 |=> !link_activity_led_o[0])
        else $error("idle link LED not low");
    AST_BLINK_FOLLOWS: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        port_link_i[0] && act_hold[0] != 2'h0 |=> link_activity_led_o[0] == $past(act_phase[0]))
        else $error("link LED not blinking");
    AST_RESET_DARK: assert property (@(posedge core_clk_i)
        !nrst_i |=> link_activity_led_o == 5'h1F && port_speed_led_o == 5'h1F)
        else $error("LEDs not dark after reset");
    AST_HALF_DUPLEX: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !port_full_duplex_i[1] && col_hold[1] == 2'h0 |=> duplex_collision_led_o[1])
        else $error("half duplex LED not high");
    AST_FULL_DUPLEX: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        port_full_duplex_i[1] && col_hold[1] == 2'h0 |=> !duplex_collision_led_o[1])
        else $error("full duplex LED not low");
    AST_SPEED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        nrst_i |=> port_speed_led_o == ~$past(port_speed100_i))
        else $error("speed LED wrong");
    AST_STRAP_FROZEN: assert property (@(posedge core_clk_i)
        nrst_i && $past(nrst_i) |-> $stable(backpressure_en_o) && $stable(chip_addr_o))
        else $error("strap changed after reset");
    AST_PINS_FLOAT: assert property (@(posedge core_clk_i)
        !nrst_i |=> eeprom_select_oe_n_o && eeprom_serial_clock_oe_n_o
                    && eeprom_serial_out_oe_n_o)
        else $error("EEPROM pins driven in reset");
    AST_RETRIGGER: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        port_collision_i[2] |=> col_hold[2] == 2'h2)
        else $error("collision did not retrigger blink");

endmodule

`default_nettype wire

// ---- logic/lss_pkg.sv ----
// Package of constants for the LED status and strap latch block.
package lss_pkg;
    localparam int unsigned NUM_PORTS      = 5;
    // Blink half period in milliseconds and its cycle count at 10 MHz.
    localparam int unsigned BLINK_HALF_MS  = 50;
    localparam int unsigned CLK_HZ         = 10000000;
    localparam int unsigned BLINK_CYCLES   = BLINK_HALF_MS * (CLK_HZ / 1000);
    // Retrigger hold: activity keeps the blink running this many half periods.
    localparam logic [1:0]  HOLD_HALVES    = 2'h2;
    localparam logic [1:0]  HOLD_RESET     = 2'h0;
    localparam logic [19:0] BLINK_RESET    = 20'h00000;
    // Strap default constants; capture never loads them, and only ADDR_RESET is used, to decode master mode.
    localparam logic        BP_RESET       = 1'h1;
    localparam logic        AN_RESET       = 1'h1;
    localparam logic [1:0]  ADDR_RESET     = 2'h0;
    localparam logic        XOV_RESET      = 1'h0;
    localparam logic        COLOR_RESET    = 1'h0;
    localparam logic [2:0]  SYNC_RESET     = 3'h0;
    // Dark level of a five-port active-low LED group, used while reset is held.
    localparam logic [4:0]  LED_DARK       = 5'h1F;
    // Serial clock divider terminal count; each half period lasts this plus one core cycles.
    localparam logic [3:0]  EE_DIV_HALF    = 4'h4;
    typedef enum logic [2:0] {
        LSS_IDLE  = 3'b001,
        LSS_READ  = 3'b010,
        LSS_DONE  = 3'b100
    } lss_ee_state_t;
endpackage

// ---- tb/lss_far_side.sv ----
// Far-side model of the strap resistors and a serial EEPROM returning one bit.
`timescale 1ns/1ps
`default_nettype none

module lss_far_side
(
    input  wire logic [5:0] strap_level_i,
    input  wire logic       rom_bit_i,
    input  wire logic       select_i,
    input  wire logic       select_oe_n_i,
    output logic [5:0]      strap_pin_o,
    output logic            serial_in_o
);
    // Resistors set the strap pins; bit order is bp, an, hi, lo, xov, color.
    assign strap_pin_o = strap_level_i;
    // An unselected EEPROM releases its data line, so the pull-up wins.
    assign serial_in_o = (select_oe_n_i === 1'b0 && select_i === 1'b1) ? rom_bit_i : 1'b1;
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench for the LED status and strap latch block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic       core_clk_i;
    logic       nrst_i;
    logic [4:0] link, act, fdx, col, spd;
    logic [5:0] strap_level, strap_pin;
    logic       rom_bit, ser_in, start;
    logic [4:0] la_led, dc_led, sp_led;
    logic       bp_en, an_en, xov_en, dual, master;
    logic [1:0] addr;
    logic       sel, sel_oe_n, sclk, sclk_oe_n, sout, sout_oe_n, bvalid, bval;
    int         miscompares;
    int         num_checks;
    int         cycles;

    lss_led_strap u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .port_link_i(link),
        .port_activity_i(act), .port_full_duplex_i(fdx), .port_collision_i(col),
        .port_speed100_i(spd), .backpressure_strap_i(strap_pin[5]),
        .autoneg_strap_i(strap_pin[4]), .chip_addr_strap_hi_i(strap_pin[3]),
        .chip_addr_strap_lo_i(strap_pin[2]), .crossover_strap_i(strap_pin[1]),
        .led_color_strap_i(strap_pin[0]), .eeprom_serial_in_i(ser_in), .eeprom_start_i(start),
        .link_activity_led_o(la_led), .duplex_collision_led_o(dc_led), .port_speed_led_o(sp_led),
        .backpressure_en_o(bp_en), .autoneg_en_o(an_en), .chip_addr_o(addr),
        .crossover_en_o(xov_en), .dual_color_o(dual), .eeprom_master_o(master),
        .eeprom_select_o(sel), .eeprom_select_oe_n_o(sel_oe_n), .eeprom_serial_clock_o(sclk),
        .eeprom_serial_clock_oe_n_o(sclk_oe_n), .eeprom_serial_out_o(sout),
        .eeprom_serial_out_oe_n_o(sout_oe_n), .eeprom_bit_valid_o(bvalid), .eeprom_bit_o(bval));

    lss_far_side u_far (.strap_level_i(strap_level), .rom_bit_i(rom_bit), .select_i(sel),
        .select_oe_n_i(sel_oe_n), .strap_pin_o(strap_pin), .serial_in_o(ser_in));

    // ------------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------------
    // A 100 ns period gives the 10 MHz core clock.
    initial
    begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    // The whole sequence needs well under 1000 cycles, so 5000 means a hang.
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [4:0] exp, input logic [4:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Holds reset for 21 cycles with the given strap levels, then releases it.
    task automatic do_reset(input logic [5:0] s);
        @(posedge core_clk_i);
        nrst_i <= 1'b0;
        strap_level <= s;
        repeat (20) @(posedge core_clk_i);
        #1;
        check("led_in_reset", 5'h1F, la_led);
        check("oe_n_in_reset", 5'h07, {2'h0, sel_oe_n, sclk_oe_n, sout_oe_n});
        @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Straps must freeze at release even though the shared pins change later.
    task automatic test_straps(input logic [5:0] s);
        do_reset(s);
        @(posedge core_clk_i);
        strap_level <= ~s;
        repeat (6) @(posedge core_clk_i);
        #1;
        check("backpressure", {4'h0, s[5]}, {4'h0, bp_en});
        check("autoneg", {4'h0, s[4]}, {4'h0, an_en});
        check("chip_addr", {3'h0, s[3:2]}, {3'h0, addr});
        check("crossover", {4'h0, s[1]}, {4'h0, xov_en});
        check("dual_color", {4'h0, s[0]}, {4'h0, dual});
        check("master", {4'h0, s[3:2] == 2'h0}, {4'h0, master});
    endtask

    // A start request while not master must never produce a bit.
    task automatic test_refused();
        int seen;
        seen = 0;
        @(posedge core_clk_i);
        start <= 1'b1;
        repeat (20)
        begin
            @(posedge core_clk_i);
            #1;
            if (bvalid !== 1'b0 || sel !== 1'b0)
                seen = 1;
        end
        @(posedge core_clk_i);
        start <= 1'b0;
        check("slave_refuses", 5'h00, seen[4:0]);
    endtask

    // Static levels: link, idle, duplex and speed indications.
    task automatic test_leds();
        @(posedge core_clk_i);
        link <= 5'h15;
        fdx <= 5'h06;
        spd <= 5'h03;
        repeat (3) @(posedge core_clk_i);
        #1;
        check("link_led", 5'h0A, la_led);
        check("duplex_led", 5'h19, dc_led);
        check("speed_led", 5'h1C, sp_led);
    endtask

    // Events retrigger the blink; the first half period shows the lit phase.
    task automatic test_events();
        @(posedge core_clk_i);
        act <= 5'h03;
        col <= 5'h0C;
        @(posedge core_clk_i);
        act <= 5'h00;
        col <= 5'h00;
        repeat (4) @(posedge core_clk_i);
        #1;
        check("activity_led", 5'h0A, la_led);
        check("collision_led", 5'h11, dc_led);
    endtask

    // One bit read from the EEPROM while the device is master.
    task automatic test_eeprom(input logic b);
        int n;
        int sel_seen;
        int clk_seen;
        n = 0;
        sel_seen = 0;
        clk_seen = 0;
        @(posedge core_clk_i);
        rom_bit <= b;
        start <= 1'b1;
        while (bvalid !== 1'b1 && n < 20)
        begin
            @(posedge core_clk_i);
            #1;
            n++;
            if (sel === 1'b1 && sel_oe_n === 1'b0)
                sel_seen = 1;
            if (sclk === 1'b1 && sclk_oe_n === 1'b0)
                clk_seen = 1;
        end
        check("bit_valid", 5'h01, {4'h0, bvalid});
        check("bit_value", {4'h0, b}, {4'h0, bval});
        check("select_high", 5'h01, sel_seen[4:0]);
        check("serial_clock", 5'h01, clk_seen[4:0]);
        check("serial_out", 5'h00, {3'h0, sout_oe_n, sout});
        // Start drops on an edge so the reader can return to idle before the next call.
        @(posedge core_clk_i);
        start <= 1'b0;
        repeat (3) @(posedge core_clk_i);
    endtask

    // ------------------------------------------------------------------
    // Verdict and main sequence
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        nrst_i = 1'b0;
        {link, act, fdx, col, spd} = 25'h0;
        strap_level = 6'h30;
        rom_bit = 1'b1;
        start = 1'b0;
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        test_straps(6'h2B);
        test_refused();
        test_straps(6'h30);
        test_leds();
        test_events();
        test_eeprom(1'b0);
        test_eeprom(1'b1);
        summarize();
    end
endmodule

`default_nettype wire
